// >>> pkg/gefl_defines.svh
// Offsets, field positions and reset values of the global event flag latch.
// Assumes inclusion by bare name from package and design files.
`ifndef GEFL_DEFINES_SVH
`define GEFL_DEFINES_SVH

`define GEFL_FLAGS_OFFSET   8'h00
`define GEFL_FLAGS_RESET    8'h00
`define GEFL_BIT_LDO_A      7
`define GEFL_BIT_LDO_B      6
`define GEFL_BIT_THERM_HIGH 5
`define GEFL_BIT_THERM_LOW  4
`define GEFL_BIT_EN_RISE    3
`define GEFL_BIT_EN_FALL    2
`define GEFL_BIT_GP0_RISE   1
`define GEFL_BIT_GP0_FALL   0

`endif

// >>> pkg/gefl_pkg.sv
// Types shared by the global event flag latch.
// Assumes gefl_defines.svh sits on the include path.
`include "gefl_defines.svh"

package gefl_pkg;
    typedef logic [7:0] gefl_flags_t;
endpackage

// >>> logic/gefl_event_latch.sv
// Global event flag register: eight sticky event bits, cleared by a read.
// Assumes the serial slave gives a one-cycle read strobe and a register
// pointer on i_clk; analog detectors and pins are asynchronous levels.
//
// Operation
// - Bit 7 sets on LDO A dropout and holds until the register is read.
// - Bit 6 sets on LDO B dropout and holds until the register is read.
// - Bit 5 sets as temperature rises over the high alarm, held until read.
// - Bit 4 sets as temperature rises over the low alarm, held until read.
// - Bit 3 sets on a rising edge of the enable pin, held until read.
// - Bit 2 sets on a falling edge of the enable pin, held until read.
// - Bit 1 sets on a rise of general input 0 set as input, held until read.
// - Bit 0 sets on a fall of general input 0 set as input, held until read.
// - The register resets to zero; a read returns the flags and clears them.
`include "gefl_defines.svh"

module gefl_event_latch
    import gefl_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_ldo_a_dropout,
    input  wire logic       i_ldo_b_dropout,
    input  wire logic       i_thermal_threshold_high,
    input  wire logic       i_thermal_threshold_low,
    input  wire logic       i_enable_pin_n,
    input  wire logic       i_general_input_pin,
    input  wire logic       i_gp0_is_input,
    input  wire logic       i_rd_strobe,
    input  wire logic [7:0] i_reg_ptr,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid,
    output logic            o_flags_pending
);

    // Every assertion below samples on i_clk and rests during reset
    default clocking cb_chk @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int N_IN = 6;
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] sync_prev;
    logic            gp0_dir1;
    logic            gp0_dir;

    assign raw_in = {i_ldo_a_dropout, i_ldo_b_dropout,
                     i_thermal_threshold_high, i_thermal_threshold_low,
                     i_enable_pin_n, i_general_input_pin};

    genvar g;
    generate
        for (g = 0; g < N_IN; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    sync1[g]     <= 1'b0;
                    sync2[g]     <= 1'b0;
                    sync_prev[g] <= 1'b0;
                end else begin
                    sync1[g]     <= raw_in[g];
                    sync2[g]     <= sync1[g];
                    sync_prev[g] <= sync2[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gp0_dir1 <= 1'b0;
            gp0_dir  <= 1'b0;
        end else begin
            gp0_dir1 <= i_gp0_is_input;
            gp0_dir  <= gp0_dir1;
        end
    end

    // ************************************************************
    // Edge arming after reset
    // ************************************************************
    // Edges stay masked until sync_prev holds a sampled level, so a
    // pin that is already high as reset ends raises no false event.
    logic [2:0] arm_sr;
    logic       armed;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            arm_sr <= 3'h0;
        end else begin
            arm_sr <= {arm_sr[1:0], 1'b1};
        end
    end

    assign armed = arm_sr[2];

    // ************************************************************
    // Event decode
    // ************************************************************
    logic [7:0] evt;
    logic [N_IN-1:0] rise;
    logic [N_IN-1:0] fall;

    assign rise = {N_IN{armed}} & sync2 & ~sync_prev;
    assign fall = {N_IN{armed}} & ~sync2 & sync_prev;

    always_comb begin
        evt = 8'h00;
        evt[`GEFL_BIT_LDO_A]      = rise[5];
        evt[`GEFL_BIT_LDO_B]      = rise[4];
        evt[`GEFL_BIT_THERM_HIGH] = rise[3];
        evt[`GEFL_BIT_THERM_LOW]  = rise[2];
        evt[`GEFL_BIT_EN_RISE]    = rise[1];
        evt[`GEFL_BIT_EN_FALL]    = fall[1];
        evt[`GEFL_BIT_GP0_RISE]   = rise[0] & gp0_dir;
        evt[`GEFL_BIT_GP0_FALL]   = fall[0] & gp0_dir;
    end

    // ************************************************************
    // Flag register and read port
    // ************************************************************
    gefl_flags_t flags;
    gefl_flags_t next_flags;
    logic        rd_hit;

    assign rd_hit = i_rd_strobe && (i_reg_ptr == `GEFL_FLAGS_OFFSET);

    always_comb begin
        next_flags = (rd_hit ? 8'h00 : flags) | evt;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags <= `GEFL_FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data       <= 8'h00;
            o_rd_valid      <= 1'b0;
            o_flags_pending <= 1'b0;
        end else begin
            o_rd_valid      <= i_rd_strobe;
            o_rd_data       <= rd_hit ? flags : 8'h00;
            o_flags_pending <= |next_flags;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_read;
        rd_hit && (evt == 8'h00);
    endsequence

    sequence s_read_answer;
        (flags == 8'h00) && o_rd_valid;
    endsequence

    sequence s_refused_take;
        i_rd_strobe && !rd_hit;
    endsequence

    sequence s_set_in_read;
        rd_hit && (evt != 8'h00);
    endsequence

    AST_LDO_A: assert property (rise[5] |=> flags[7])
        else $error("ldo a dropout not latched");
    AST_LDO_B: assert property (rise[4] |=> flags[6])
        else $error("ldo b dropout not latched");
    AST_THERM_HIGH: assert property (rise[3] |=> flags[5])
        else $error("high alarm not latched");
    AST_THERM_LOW: assert property (rise[2] |=> flags[4])
        else $error("low alarm not latched");
    AST_EN_RISE: assert property (rise[1] |=> flags[3])
        else $error("enable rise not latched");
    AST_EN_FALL: assert property (fall[1] |=> flags[2])
        else $error("enable fall not latched");
    AST_GP_RISE: assert property (
        (!gp0_dir && !flags[1]) |=> !flags[1])
        else $error("general input rise flag set while output");
    AST_GP_RISE_ON: assert property ((gp0_dir && rise[0]) |=> flags[1])
        else $error("general input rise not latched");
    AST_GP_FALL: assert property ((gp0_dir && fall[0]) |=> flags[0])
        else $error("general input fall not latched");
    AST_GP_FALL_OFF: assert property (
        (!gp0_dir && !flags[0]) |=> !flags[0])
        else $error("general input fall flag set while output");
    AST_READ_CLEAR: assert property (
        s_read |=> s_read_answer ##0 (o_rd_data == $past(flags)))
        else $error("read did not return and clear flags");
    AST_VALID_PULSE: assert property (i_rd_strobe |=> o_rd_valid)
        else $error("read strobe gave no valid pulse");
    AST_VALID_IDLE: assert property (!i_rd_strobe |=> !o_rd_valid)
        else $error("valid pulse without a read strobe");
    AST_REFUSED: assert property (s_refused_take |=> (o_rd_data == 8'h00))
        else $error("other pointer returned flag data");
    AST_SET_WINS: assert property (s_set_in_read |=> (flags == $past(evt)))
        else $error("event lost in a clearing read");
    AST_STICKY: assert property (
        !rd_hit |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag lost without read");

endmodule // gefl_event_latch

// >>> tb/gefl_host.sv
// Host model that fetches the flag register over the read port.
// Assumes the latch answers one cycle after the taken strobe.
module gefl_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output logic            o_rd_strobe,
    output logic      [7:0] o_reg_ptr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rd_strobe = 1'b0;
        o_reg_ptr   = 8'h00;
    end
    task automatic read(input logic [7:0] p, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_rd_strobe = 1'b1;
        o_reg_ptr   = p;
        @(posedge i_clk);
        #1;
        o_rd_strobe = 1'b0;
        o_reg_ptr   = ~p;
        d = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
endmodule // gefl_host

// >>> tb/global_event_flag_latch_tb.sv
// Testbench for the global event flag latch: pin events and flag reads.
// Assumes gefl_pkg, the latch and the host model are compiled first.
module global_event_flag_latch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gefl_pkg::*;
    logic        clk;
    logic        arst_n;
    logic [5:0]  ev;
    logic        gp_in;
    logic        stb;
    logic [7:0]  ptr;
    gefl_flags_t rdata;
    logic        rvalid;
    logic        pend;
    gefl_flags_t got;
    int          n_fail = 0;
    int          n_tests = 0;
    gefl_flags_t rise_m [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    gefl_flags_t fall_m [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01};

    gefl_event_latch dut (.i_clk(clk), .i_arst_n(arst_n),
        .i_ldo_a_dropout(ev[0]), .i_ldo_b_dropout(ev[1]),
        .i_thermal_threshold_high(ev[2]), .i_thermal_threshold_low(ev[3]),
        .i_enable_pin_n(ev[4]), .i_general_input_pin(ev[5]),
        .i_gp0_is_input(gp_in), .i_rd_strobe(stb), .i_reg_ptr(ptr),
        .o_rd_data(rdata), .o_rd_valid(rvalid), .o_flags_pending(pend));
    gefl_host host (.i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
        .o_rd_strobe(stb), .o_reg_ptr(ptr));

    task automatic chk(input gefl_flags_t exp, input gefl_flags_t act);
        n_tests++;
        if (act !== exp) begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic chk_bit(input logic exp, input logic act);
        n_tests++;
        if (act !== exp) begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic rd(input logic [7:0] p, input gefl_flags_t exp);
        host.read(p, got);
        chk(exp, got);
        chk_bit(1'b1, rvalid);
        @(posedge clk);
        #1;
        chk_bit(1'b0, rvalid);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_sources();
        for (int i = 0; i < 6; i++) begin
            ev[i] = 1'b1;
            settle();
            chk_bit(1'b1, pend);
            rd(8'h00, rise_m[i]);
            rd(8'h00, 8'h00);
            chk_bit(1'b0, pend);
            ev[i] = 1'b0;
            settle();
            chk_bit(fall_m[i] != 8'h00, pend);
            rd(8'h00, fall_m[i]);
        end
    endtask
    task automatic t_set_wins();
        ev[1] = 1'b1;
        @(posedge clk);
        host.read(8'h00, got);
        chk(8'h00, got);
        rd(8'h00, 8'h40);
        ev[1] = 1'b0;
        settle();
        rd(8'h00, 8'h00);
    endtask
    task automatic t_gp_off();
        gp_in = 1'b0;
        settle();
        ev[5] = 1'b1;
        settle();
        chk_bit(1'b0, pend);
        rd(8'h00, 8'h00);
        ev[5] = 1'b0;
        settle();
        rd(8'h00, 8'h00);
        gp_in = 1'b1;
    endtask
    task automatic t_wrong_ptr();
        ev[0] = 1'b1;
        settle();
        rd(8'h01, 8'h00);
        chk_bit(1'b1, pend);
        rd(8'h00, 8'h80);
        ev[0] = 1'b0;
        settle();
        chk_bit(1'b0, pend);
    endtask
    task automatic t_reset();
        ev[0] = 1'b1;
        settle();
        chk_bit(1'b1, pend);
        arst_n = 1'b0;
        settle();
        chk(8'h00, rdata);
        chk_bit(1'b0, rvalid);
        chk_bit(1'b0, pend);
        arst_n = 1'b1;
        settle();
        chk_bit(1'b0, pend);
        rd(8'h00, 8'h00);
        ev[0] = 1'b0;
        settle();
        rd(8'h00, 8'h00);
    endtask
    task automatic complete_run();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        ev     = 6'h00;
        gp_in  = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b1;
        settle();
        rd(8'h00, 8'h00);
        t_sources();
        t_set_wins();
        t_gp_off();
        t_wrong_ptr();
        t_reset();
        complete_run();
    end
endmodule // global_event_flag_latch_tb
